/* src/startup_pkg.sv */
package startup_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam int CTRL_SLEEP_BIT = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_DIV8_BIT = 8;
    localparam int STAT_RANGE_LSB = 9;
    localparam int STAT_LPX_BIT = 12;
    localparam int STAT_TOUT_BIT = 13;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    localparam int TOUT_NONE_CYC = 0;
    localparam int TOUT_SHORT_CYC = 4096;
    localparam int TOUT_LONG_CYC = 8192;
    localparam int STAB_EXT_CYC = 6;
    localparam int STAB_258_CYC = 258;
    localparam int STAB_1K_CYC = 1024;
    localparam int STAB_16K_CYC = 16384;
    localparam int STAB_32K_CYC = 32768;
    localparam int RESET_EXTRA_CYC = 14;
    localparam int SYSCLK_DIV = 8;

    // ------------------------------------------------------------
    // fuse encodings (raw fuse levels: 1 unprogrammed, 0 programmed)
    // ------------------------------------------------------------
    localparam logic [3:0] FUSE_RST_CLOCK_SOURCE_SELECT_FUSES = 4'h2;
    localparam logic [1:0] FUSE_RST_SUT = 2'h2;
    localparam logic FUSE_RST_DIV8 = 1'b0;

    typedef enum logic [5:0] {
        ST_HOLD = 6'b00_0001,
        ST_TOUT = 6'b00_0010,
        ST_STAB = 6'b00_0100,
        ST_RUN = 6'b00_1000,
        ST_SLEEP = 6'b01_0000,
        ST_WAKE = 6'b10_0000
    } seq_state_e;
endpackage : startup_pkg

/* src/ripple_cnt_if.sv */
`timescale 1ns/1ps
interface ripple_cnt_if #(parameter int W = 16);
    logic clr;
    logic tick;
    logic [W-1:0] target;
    logic [W-1:0] count;
    logic done;
    modport ctl (output clr, output tick, output target, input count, input done);
    modport ctr (input clr, input tick, input target, output count, output done);
endinterface : ripple_cnt_if

/* src/ripple_counter.sv */
`timescale 1ns/1ps
module ripple_counter #(
    parameter int W = 16
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    ripple_cnt_if.ctr cnt
);
    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;
    logic done_ff;
    logic nxt_done;

    initial
    begin
        if (W < 2 || W > 31)
            $error("ripple_counter: width out of range");
    end

    // counts ticks of the watched clock; holds once the target is met
    always_comb
    begin
        nxt_count = count_ff;
        if (cnt.clr)
            nxt_count = '0;
        else if (cnt.tick && count_ff != cnt.target)
            nxt_count = count_ff + W'(1);
        nxt_done = !cnt.clr && (nxt_count == cnt.target);
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            count_ff <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            done_ff <= nxt_done;
        end
    end

    assign cnt.count = count_ff;
    assign cnt.done = done_ff;

    property p_cnt_step;
        @(posedge i_mclk) disable iff (i_sys_rst)
        cnt.tick && !cnt.clr && count_ff != cnt.target |=> count_ff == $past(count_ff) + W'(1);
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter missed a tick");

    property p_cnt_clr;
        @(posedge i_mclk) disable iff (i_sys_rst)
        cnt.clr |=> count_ff == '0 && !done_ff;
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared");
endmodule : ripple_counter

/* src/clock_startup_reset_sequencer.sv */
`timescale 1ns/1ps
module clock_startup_reset_sequencer #(
    parameter int TOUT_LONG = startup_pkg::TOUT_LONG_CYC,
    parameter int STAB_16K = startup_pkg::STAB_16K_CYC,
    parameter int STAB_32K = startup_pkg::STAB_32K_CYC,
    parameter int CW = 16
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_other_rst,
    input wire logic i_wdt_osc_tick,
    input wire logic i_osc_tick,
    input wire logic i_wake,
    input wire logic [3:0] i_clock_source_select_fuses,
    input wire logic [1:0] i_startup_time_fuses,
    input wire logic i_divide_by_eight_fuse,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_int_rst,
    output logic o_sys_tick,
    output logic [2:0] o_oscillator_range_fuses
);
    initial
    begin
        if (CW < 16 || STAB_32K + startup_pkg::RESET_EXTRA_CYC >= 2 ** CW || TOUT_LONG >= 2 ** CW)
            $error("sequencer: counter width cannot hold the counts");
    end

    // ------------------------------------------------------------
    // fuse capture and decode
    // ------------------------------------------------------------
    logic [3:0] clock_source_select_fuses_ff;
    logic [1:0] sut_ff;
    logic div8_ff;
    logic [3:0] nxt_clock_source_select_fuses;
    logic [1:0] nxt_sut;
    logic nxt_div8;
    logic [CW-1:0] tout_target;
    logic [CW-1:0] wake_target;
    logic lp_xtal;
    startup_pkg::seq_state_e state_ff;
    startup_pkg::seq_state_e nxt_state;

    // only captured while held, so counts cannot shift mid-sequence
    always_comb
    begin
        nxt_clock_source_select_fuses = clock_source_select_fuses_ff;
        nxt_sut = sut_ff;
        nxt_div8 = div8_ff;
        if (state_ff == startup_pkg::ST_HOLD)
        begin
            nxt_clock_source_select_fuses = i_clock_source_select_fuses;
            nxt_sut = i_startup_time_fuses;
            nxt_div8 = !i_divide_by_eight_fuse;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            clock_source_select_fuses_ff <= startup_pkg::FUSE_RST_CLOCK_SOURCE_SELECT_FUSES;
            sut_ff <= startup_pkg::FUSE_RST_SUT;
            div8_ff <= !startup_pkg::FUSE_RST_DIV8;
        end
        else
        begin
            clock_source_select_fuses_ff <= nxt_clock_source_select_fuses;
            sut_ff <= nxt_sut;
            div8_ff <= nxt_div8;
        end
    end

    // crystal table shared by low-power and full-swing; codes taken as raw levels
    always_comb
    begin
        lp_xtal = clock_source_select_fuses_ff[3];
        tout_target = CW'(startup_pkg::TOUT_NONE_CYC);
        wake_target = CW'(startup_pkg::STAB_EXT_CYC);
        if (clock_source_select_fuses_ff[3] || clock_source_select_fuses_ff[3:1] == 3'b011)
        begin
            unique case ({clock_source_select_fuses_ff[0], sut_ff})
                3'b000: wake_target = CW'(startup_pkg::STAB_258_CYC);
                3'b001: wake_target = CW'(startup_pkg::STAB_258_CYC);
                3'b010: wake_target = CW'(startup_pkg::STAB_1K_CYC);
                3'b011: wake_target = CW'(startup_pkg::STAB_1K_CYC);
                3'b100: wake_target = CW'(startup_pkg::STAB_1K_CYC);
                default: wake_target = CW'(STAB_16K);
            endcase
            unique case ({clock_source_select_fuses_ff[0], sut_ff})
                3'b000, 3'b011, 3'b110: tout_target = CW'(startup_pkg::TOUT_SHORT_CYC);
                3'b001, 3'b100, 3'b111: tout_target = CW'(TOUT_LONG);
                default: tout_target = CW'(startup_pkg::TOUT_NONE_CYC);
            endcase
        end
        else if (clock_source_select_fuses_ff[3:1] == 3'b010)
        begin
            // low-frequency crystal; reserved start-up code 11 falls back to long
            wake_target = clock_source_select_fuses_ff[0] ? CW'(STAB_32K) : CW'(startup_pkg::STAB_1K_CYC);
            unique case (sut_ff)
                2'b00: tout_target = CW'(startup_pkg::TOUT_NONE_CYC);
                2'b01: tout_target = CW'(startup_pkg::TOUT_SHORT_CYC);
                default: tout_target = CW'(TOUT_LONG);
            endcase
        end
        else
        begin
            // RC and external sources: time-out still from watchdog ticks
            unique case (sut_ff)
                2'b00: tout_target = CW'(startup_pkg::TOUT_NONE_CYC);
                2'b01: tout_target = CW'(startup_pkg::TOUT_SHORT_CYC);
                default: tout_target = CW'(TOUT_LONG);
            endcase
        end
    end

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    ripple_cnt_if #(.W(CW)) tout_if ();
    ripple_cnt_if #(.W(CW)) stab_if ();

    ripple_counter #(.W(CW)) u_tout_cnt (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .cnt(tout_if.ctr)
    );
    ripple_counter #(.W(CW)) u_stab_cnt (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .cnt(stab_if.ctr)
    );

    assign tout_if.clr = state_ff != startup_pkg::ST_TOUT;
    assign tout_if.tick = i_wdt_osc_tick;
    assign tout_if.target = tout_target;
    assign stab_if.clr = !(state_ff == startup_pkg::ST_STAB || state_ff == startup_pkg::ST_WAKE);
    assign stab_if.tick = i_osc_tick;
    // reset path adds the extra 14 clocks on top of the wake count
    assign stab_if.target = (state_ff == startup_pkg::ST_WAKE) ? wake_target
        : wake_target + CW'(startup_pkg::RESET_EXTRA_CYC);

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    logic sleep_req;
    logic int_rst_ff;
    logic nxt_int_rst;

    always_comb
    begin
        nxt_state = state_ff;
        if (i_other_rst)
            nxt_state = startup_pkg::ST_HOLD;
        else
        begin
            unique case (state_ff)
                startup_pkg::ST_HOLD:
                    nxt_state = (tout_target == '0) ? startup_pkg::ST_STAB : startup_pkg::ST_TOUT;
                startup_pkg::ST_TOUT:
                    if (tout_if.done)
                        nxt_state = startup_pkg::ST_STAB;
                startup_pkg::ST_STAB, startup_pkg::ST_WAKE:
                    if (stab_if.done)
                        nxt_state = startup_pkg::ST_RUN;
                startup_pkg::ST_RUN:
                    if (sleep_req)
                        nxt_state = startup_pkg::ST_SLEEP;
                startup_pkg::ST_SLEEP:
                    if (i_wake)
                        nxt_state = startup_pkg::ST_WAKE;
            endcase
        end
        nxt_int_rst = nxt_state inside {startup_pkg::ST_HOLD, startup_pkg::ST_TOUT, startup_pkg::ST_STAB};
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            state_ff <= startup_pkg::ST_HOLD;
            int_rst_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            int_rst_ff <= nxt_int_rst;
        end
    end

    // ------------------------------------------------------------
    // system clock divider
    // ------------------------------------------------------------
    logic [2:0] div_ff;
    logic [2:0] nxt_div;
    logic sys_tick_ff;
    logic nxt_sys_tick;

    always_comb
    begin
        nxt_div = div_ff;
        nxt_sys_tick = 1'b0;
        if (state_ff != startup_pkg::ST_RUN)
            nxt_div = '0;
        else if (i_osc_tick)
        begin
            nxt_div = div_ff + 3'd1;
            nxt_sys_tick = !div8_ff || div_ff == 3'(startup_pkg::SYSCLK_DIV - 1);
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            div_ff <= '0;
            sys_tick_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            sys_tick_ff <= nxt_sys_tick;
        end
    end

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] nxt_prdata;
    logic nxt_pready;
    logic nxt_pslverr;
    logic setup;
    logic hit;
    logic [31:0] status;

    assign setup = i_psel && !i_penable;
    assign hit = i_paddr == startup_pkg::CTRL_OFS || i_paddr == startup_pkg::STATUS_OFS;
    // sleep only honoured from run; the bit self-clears
    assign sleep_req = i_psel && i_penable && pready_ff && i_pwrite && i_paddr == startup_pkg::CTRL_OFS
        && i_pwdata[startup_pkg::CTRL_SLEEP_BIT];

    always_comb
    begin
        status = '0;
        status[startup_pkg::STAT_STATE_LSB +: 6] = state_ff;
        status[startup_pkg::STAT_DIV8_BIT] = div8_ff;
        status[startup_pkg::STAT_RANGE_LSB +: 3] = clock_source_select_fuses_ff[3:1];
        status[startup_pkg::STAT_LPX_BIT] = lp_xtal;
        status[startup_pkg::STAT_TOUT_BIT] = tout_target != '0;
        nxt_pready = setup;
        nxt_pslverr = setup && !hit;
        nxt_prdata = prdata_ff;
        if (setup)
            nxt_prdata = (i_paddr == startup_pkg::STATUS_OFS) ? status : startup_pkg::CTRL_RST;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_int_rst = int_rst_ff;
    assign o_sys_tick = sys_tick_ff;
    assign o_oscillator_range_fuses = clock_source_select_fuses_ff[3:1];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_released;
        state_ff == startup_pkg::ST_TOUT && int_rst_ff;
    endsequence

    property p_hold_while_other;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_other_rst |=> int_rst_ff && state_ff == startup_pkg::ST_HOLD;
    endproperty
    a_hold_while_other: assert property (p_hold_while_other) else $error("reset released early");

    property p_start_seq;
        @(posedge i_mclk) disable iff (i_sys_rst)
        state_ff == startup_pkg::ST_HOLD && !i_other_rst && tout_target != '0 |=> s_released;
    endproperty
    a_start_seq: assert property (p_start_seq) else $error("time-out not entered");

    property p_wake_skip;
        @(posedge i_mclk) disable iff (i_sys_rst)
        state_ff == startup_pkg::ST_SLEEP && i_wake && !i_other_rst |=> state_ff == startup_pkg::ST_WAKE && !int_rst_ff;
    endproperty
    a_wake_skip: assert property (p_wake_skip) else $error("wake ran the time-out");

    property p_release_on_done;
        @(posedge i_mclk) disable iff (i_sys_rst)
        $fell(int_rst_ff) |-> $past(stab_if.done) && $past(state_ff) == startup_pkg::ST_STAB;
    endproperty
    a_release_on_done: assert property (p_release_on_done) else $error("released before stable");

    property p_fuses_frozen;
        @(posedge i_mclk) disable iff (i_sys_rst)
        $past(state_ff) != startup_pkg::ST_HOLD |-> $stable(clock_source_select_fuses_ff) && $stable(sut_ff);
    endproperty
    a_fuses_frozen: assert property (p_fuses_frozen) else $error("fuses changed mid-sequence");

    property p_tout_len;
        @(posedge i_mclk) disable iff (i_sys_rst)
        state_ff == startup_pkg::ST_TOUT && tout_if.done |-> tout_if.count == tout_target;
    endproperty
    a_tout_len: assert property (p_tout_len) else $error("time-out length wrong");

    property p_div8_gap;
        @(posedge i_mclk) disable iff (i_sys_rst)
        sys_tick_ff && div8_ff |-> $past(div_ff) == 3'(startup_pkg::SYSCLK_DIV - 1);
    endproperty
    a_div8_gap: assert property (p_div8_gap) else $error("divide by eight broken");
endmodule : clock_startup_reset_sequencer

/* test/osc_partner.sv */
`timescale 1ns/1ps
module osc_partner (
    input wire logic i_mclk,
    input wire logic i_hold,
    input wire logic [1:0] i_wdt_div,
    output logic o_other_rst,
    output logic o_wdt_tick,
    output logic o_osc_tick
);
    logic [1:0] wdt_cnt;

    // ------------------------------------------------------------
    // other reset sources and the two oscillators
    // ------------------------------------------------------------
    assign o_other_rst = i_hold;
    initial
    begin
        wdt_cnt = 2'h0;
        o_wdt_tick = 1'b0;
        o_osc_tick = 1'b0;
    end
    // watchdog oscillator runs free, slowed by i_wdt_div
    always @(posedge i_mclk)
    begin
        wdt_cnt <= (wdt_cnt == i_wdt_div) ? 2'h0 : wdt_cnt + 2'h1;
        o_wdt_tick <= (wdt_cnt == i_wdt_div);
        o_osc_tick <= 1'b1;
    end
endmodule : osc_partner

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic i_mclk, i_sys_rst, hold, i_wake, div8, err, bad;
    logic i_psel, i_penable, i_pwrite;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic [3:0] cs;
    logic [1:0] sut, wdiv;
    logic other_rst, wdt_tick, osc_tick, o_pready, o_pslverr, o_int_rst, o_sys_tick;
    logic [2:0] o_oscillator_range_fuses;
    int n_errors, total_checks, k0, k1, kw, d, n;
    int wk[8] = '{258, 258, 1024, 1024, 1024, 64, 64, 64};
    int to[8] = '{4096, 40, 0, 4096, 40, 0, 4096, 40};
    logic [3:0] wc[3] = '{4'h0, 4'hA, 4'hB};
    int we[3] = '{6, 258, 64};

    clock_startup_reset_sequencer #(.TOUT_LONG(40), .STAB_16K(64), .STAB_32K(96))
        clock_startup_reset_sequencer_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_other_rst(other_rst), .i_wdt_osc_tick(wdt_tick), .i_osc_tick(osc_tick),
        .i_wake(i_wake), .i_clock_source_select_fuses(cs), .i_startup_time_fuses(sut),
        .i_divide_by_eight_fuse(div8), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .o_int_rst(o_int_rst),
        .o_sys_tick(o_sys_tick), .o_oscillator_range_fuses(o_oscillator_range_fuses));
    osc_partner osc_partner_inst (.i_mclk(i_mclk), .i_hold(hold), .i_wdt_div(wdiv),
        .o_other_rst(other_rst), .o_wdt_tick(wdt_tick), .o_osc_tick(osc_tick));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int t;
        t = 0;
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        @(posedge i_mclk);
        while (o_pready !== 1'b1 && t < 16)
        begin
            t++;
            @(posedge i_mclk);
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        check(32'(t < 16), 32'h0000_0001);
        // idle edge so a following call never reassigns psel in this time step
        @(posedge i_mclk);
    endtask : apb

    // mode 1 pulses another reset mid-sequence, mode 2 disturbs the fuses
    task automatic startup(input logic [3:0] c, input logic [1:0] s, input int mode, output int dur);
        hold <= 1'b1;
        cs <= c;
        sut <= s;
        repeat (4) @(posedge i_mclk);
        hold <= 1'b0;
        dur = 0;
        @(posedge i_mclk);
        while (o_int_rst !== 1'b0 && dur < 9000)
        begin
            if (mode == 1 && dur == 50) hold <= 1'b1;
            if (mode == 2 && dur == 10) cs <= 4'h0;
            dur++;
            @(posedge i_mclk);
            if (mode == 1 && dur == 54)
            begin
                hold <= 1'b0;
                dur = 0;
                mode = 0;
                @(posedge i_mclk);
            end
        end
    endtask : startup

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // clock, watchdog and tests
    // ------------------------------------------------------------
    initial
    begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    initial
    begin
        repeat (90000) @(posedge i_mclk);
        n_errors++;
        finish_test();
    end

    initial
    begin
        i_sys_rst = 1'b1;
        hold = 1'b1;
        i_wake = 1'b0;
        div8 = 1'b1;
        {i_psel, i_penable, i_pwrite} = 3'h0;
        i_paddr = 12'h000;
        i_pwdata = 32'h0000_0000;
        cs = 4'h0;
        sut = 2'h0;
        wdiv = 2'h0;
        repeat (6) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        // time-out disabled: a brown-out detector is taken to guard supply
        startup(4'h0, 2'h0, 0, d);
        k0 = d - 20;
        check(32'(k0 > 0 && k0 < 5), 32'h0000_0001);
        apb(1'b0, startup_pkg::STATUS_OFS, 32'h0000_0000);
        check(rd, 32'h0000_0008);
        div8 <= 1'b0;
        startup(4'h2, 2'h2, 0, d);
        k1 = d - 60;
        check(32'(k1 > 0 && k1 < 6), 32'h0000_0001);
        apb(1'b0, startup_pkg::STATUS_OFS, 32'h0000_0000);
        check(rd, 32'h0000_2308);
        n = 0;
        repeat (64)
        begin
            @(posedge i_mclk);
            if (o_sys_tick === 1'b1) n++;
        end
        check(32'(n), 32'h0000_0008);
        div8 <= 1'b1;
        wdiv <= 2'h3;
        startup(4'h2, 2'h2, 0, d);
        check(32'(d >= k1 + 176 && d <= k1 + 184), 32'h0000_0001);
        wdiv <= 2'h0;
        $display("reference start-up test done");
        // range codes 100 to 111 across all eight crystal start-up options
        for (int i = 0; i < 8; i++)
        begin
            startup({1'b1, i[1:0], i[2]}, i[1:0], 0, d);
            check(32'(d), 32'(to[i] + wk[i] + 14 + (to[i] != 0 ? k1 : k0)));
            check(32'(o_oscillator_range_fuses), {29'h0, 1'b1, i[1:0]});
        end
        startup(4'h5, 2'h0, 0, d);
        check(32'(d), 32'(110 + k0));
        $display("fuse decode test done");
        startup(4'hF, 2'h3, 1, d);
        check(32'(d), 32'(118 + k1));
        startup(4'hF, 2'h3, 2, d);
        check(32'(d), 32'(118 + k1));
        check(32'(o_oscillator_range_fuses), 32'h0000_0007);
        $display("restart test done");
        for (int j = 0; j < 3; j++)
        begin
            startup(wc[j], 2'(j > 0), 0, d);
            apb(1'b1, startup_pkg::CTRL_OFS, 32'h0000_0001);
            apb(1'b0, startup_pkg::STATUS_OFS, 32'h0000_0000);
            check(32'(rd[5:0]), 32'h0000_0010);
            bad = 1'b0;
            i_wake <= 1'b1;
            @(posedge i_mclk);
            i_wake <= 1'b0;
            d = 0;
            while (o_sys_tick !== 1'b1 && d < 2000)
            begin
                d++;
                @(posedge i_mclk);
                if (o_int_rst !== 1'b0) bad = 1'b1;
            end
            if (j == 0) kw = d - 6;
            check(32'(d), 32'(we[j] + kw));
            check(32'(bad), 32'h0000_0000);
        end
        $display("wake test done");
        apb(1'b0, 12'h008, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
        apb(1'b0, startup_pkg::CTRL_OFS, 32'h0000_0000);
        check({rd[30:0], err}, 32'h0000_0000);
        apb(1'b1, 12'h00C, 32'h0000_0001);
        apb(1'b0, startup_pkg::STATUS_OFS, 32'h0000_0000);
        check(32'(rd[5:0]), 32'h0000_0008);
        $display("register access test done");
        finish_test();
    end
endmodule : testbench
